// ---- panel_ctrl_pkg.sv ----
// Constants and types shared by the front-panel control logic.
// Assumes a single 40 MHz system clock domain.
package panel_ctrl_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  // Frequency held in units of 1 mHz: 2.00 mHz .. 20.00 MHz
  localparam logic [34:0] FREQ_MIN = 35'h0_0000_0002;
  localparam logic [34:0] FREQ_MAX = 35'h4_A817_C800;
  localparam logic [10:0] LIN_MIN = 11'h002;
  localparam logic [10:0] LIN_MAX = 11'h7D0;
  localparam logic [4:0] CELL_MAX = 5'h1E;
  localparam logic [4:0] ADDR_MAX = 5'h1F;
  localparam logic [7:0] DUTY_HALF = 8'h80;
  localparam logic [3:0] SHAPE_LAST_BASE = 4'h5;
  localparam logic [3:0] SHAPE_LAST_PULSE = 4'hC;
  localparam logic [3:0] SHAPE_DC = 4'h2;
  localparam logic [1:0] DIR_UP = 2'h0;
  localparam logic [1:0] DIR_DN = 2'h1;
  localparam logic [1:0] DIR_UPDN = 2'h2;
  localparam logic [1:0] DIR_DNUP = 2'h3;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_SWEEP = 4'h1;
  localparam logic [3:0] MODE_VCO = 4'h2;
  localparam logic [3:0] MODE_PULSE = 4'h4;
  typedef enum logic [1:0] {KEY_IDLE, KEY_SHIFT, KEY_DIR} key_state_type;
  typedef enum logic [1:0] {SW_IDLE, SW_FWD, SW_BACK} sweep_state_type;
endpackage

// ---- panel_ctrl.sv ----
// Front-panel control: parameter clamping, waveform, stand-by, mode, sweep.
// Assumes key inputs are debounced pulses from logic on clk.
module panel_ctrl
  import panel_ctrl_pkg::*;
#(
  parameter logic PULSE_VARIANT = 1'b0,
  parameter int BLINK_COUNT = BLINK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic shiftKey,
  input wire logic outputDisconnectKey,
  input wire logic outUpKey,
  input wire logic outDownKey,
  input wire logic modeKey,
  input wire logic scaleKey,
  input wire logic sweepDirectionKey,
  input wire logic executeKey,
  input wire logic stepUp,
  input wire logic stepDown,
  input wire logic [1:0] stepDigit,
  input wire logic rangeUp,
  input wire logic rangeDown,
  input wire logic [2:0] paramSel,
  input wire logic triggerMode,
  input wire logic trigger,
  input wire logic sweepTick,
  input wire logic [34:0] vcoLevel,
  input wire logic [7:0] pulseWidthSetting,
  input wire logic widthError,
  output logic [34:0] outFreq,
  output logic [34:0] startFreq,
  output logic [34:0] stopLog,
  output logic [10:0] stopLin,
  output logic [10:0] markLin,
  output logic [4:0] cellIndex,
  output logic [4:0] busAddress,
  output logic [2:0] rangeIndex,
  output logic [3:0] shape,
  output logic [13:0] shapeLamp,
  output logic outputConnected,
  output logic [3:0] mode,
  output logic logScale,
  output logic [1:0] sweepDir,
  output logic [1:0] shownDir,
  output logic showDir,
  output logic queryPrompt,
  output logic [7:0] dutySetting,
  output logic [10:0] sweepPos
);

  //////////////////////////////////////////////////////////////////////////////
  // Key sequencing

  key_state_type keyState;
  wire armed = (keyState == KEY_SHIFT);
  wire doStandby = armed && outputDisconnectKey;
  wire doScale = armed && scaleKey;
  wire doDirShow = armed && sweepDirectionKey;
  wire outKey = outUpKey || outDownKey;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keyState <= KEY_IDLE;
    end else begin
      unique case (keyState)
        KEY_IDLE: begin
          if (shiftKey) keyState <= KEY_SHIFT;
        end
        KEY_SHIFT: begin
          if (shiftKey) keyState <= KEY_IDLE;
          else if (doDirShow) keyState <= KEY_DIR;
          else if (doStandby || doScale) keyState <= KEY_IDLE;
        end
        KEY_DIR: begin
          if (executeKey || shiftKey) keyState <= KEY_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parameter editing; frequency digit steps scale with the range, linear steps do not

  wire editIdle = (keyState == KEY_IDLE);
  wire [34:0] digitWeight = (stepDigit == 2'h0) ? 35'h0_0000_0001 :
                            (stepDigit == 2'h1) ? 35'h0_0000_000A : 35'h0_0000_0064;
  // Shift amount widened so range codes above 2 do not wrap to a small weight
  wire [34:0] rangeWeight = 35'h0_0000_0001 << ({3'h0, rangeIndex} * 6'h03);
  wire [34:0] stepAmt = 35'((digitWeight * rangeWeight));
  wire [34:0] freqUp = ((FREQ_MAX - startFreq) < stepAmt) ? FREQ_MAX : startFreq + stepAmt;
  wire [34:0] freqDn = ((startFreq - FREQ_MIN) < stepAmt) ? FREQ_MIN : startFreq - stepAmt;
  wire [34:0] stopUp = ((FREQ_MAX - stopLog) < stepAmt) ? FREQ_MAX : stopLog + stepAmt;
  wire [34:0] stopDn = ((stopLog - FREQ_MIN) < stepAmt) ? FREQ_MIN : stopLog - stepAmt;
  wire [10:0] smallStep = digitWeight[10:0];
  wire [10:0] linUp = ((LIN_MAX - stopLin) < smallStep) ? LIN_MAX : stopLin + smallStep;
  wire [10:0] linDn = ((stopLin - LIN_MIN) < smallStep) ? LIN_MIN : stopLin - smallStep;
  wire [10:0] mkUp = ((LIN_MAX - markLin) < smallStep) ? LIN_MAX : markLin + smallStep;
  wire [10:0] mkDn = ((markLin - LIN_MIN) < smallStep) ? LIN_MIN : markLin - smallStep;
  wire stepAny = editIdle && (stepUp || stepDown);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      startFreq <= FREQ_MIN;
      stopLog <= FREQ_MAX;
      stopLin <= LIN_MAX;
      markLin <= LIN_MIN;
      cellIndex <= 5'h00;
      busAddress <= 5'h00;
      rangeIndex <= 3'h0;
    end else begin
      if (editIdle && rangeUp && rangeIndex != 3'h7) rangeIndex <= rangeIndex + 3'h1;
      else if (editIdle && rangeDown && rangeIndex != 3'h0) rangeIndex <= rangeIndex - 3'h1;
      if (stepAny && paramSel == 3'h0) startFreq <= stepUp ? freqUp : freqDn;
      if (stepAny && paramSel == 3'h1) stopLog <= stepUp ? stopUp : stopDn;
      if (stepAny && paramSel == 3'h2) stopLin <= stepUp ? linUp : linDn;
      if (stepAny && paramSel == 3'h3) markLin <= stepUp ? mkUp : mkDn;
      if (stepAny && paramSel == 3'h4) begin
        if (stepUp && cellIndex != CELL_MAX) cellIndex <= cellIndex + 5'h01;
        else if (stepDown && cellIndex != 5'h00) cellIndex <= cellIndex - 5'h01;
      end
      if (stepAny && paramSel == 3'h5) begin
        if (stepUp && busAddress != ADDR_MAX) busAddress <= busAddress + 5'h01;
        else if (stepDown && busAddress != 5'h00) busAddress <= busAddress - 5'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Waveform selection and stand-by

  wire [3:0] lastShape = PULSE_VARIANT ? SHAPE_LAST_PULSE : SHAPE_LAST_BASE;
  wire [3:0] upRaw = (shape == lastShape) ? 4'h0 : shape + 4'h1;
  wire [3:0] dnRaw = (shape == 4'h0) ? lastShape : shape - 4'h1;
  wire skipDc = PULSE_VARIANT;
  wire [3:0] shapeUp = (skipDc && upRaw == SHAPE_DC) ? upRaw + 4'h1 : upRaw;
  wire [3:0] shapeDn = (skipDc && dnRaw == SHAPE_DC) ? dnRaw - 4'h1 : dnRaw;
  logic [31:0] blinkCount;
  logic blinkPhase;
  wire lampOff = !outputConnected || ((mode == MODE_PULSE) && widthError && blinkPhase);
  wire [13:0] oneHot = 14'h0001 << shape;
  wire [13:0] next_shapeLamp = lampOff ? 14'h0000 : oneHot;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shape <= 4'h0;
      outputConnected <= 1'b1;
      shapeLamp <= 14'h0000;
      blinkCount <= 32'h0000_0000;
      blinkPhase <= 1'b0;
    end else begin
      if (doStandby) outputConnected <= 1'b0;
      else if (editIdle && outKey && !outputConnected) outputConnected <= 1'b1;
      else if (editIdle && outUpKey) shape <= shapeUp;
      else if (editIdle && outDownKey) shape <= shapeDn;
      if (blinkCount >= 32'(BLINK_COUNT - 1)) begin
        blinkCount <= 32'h0000_0000;
        blinkPhase <= !blinkPhase;
      end else begin
        blinkCount <= blinkCount + 32'h0000_0001;
      end
      shapeLamp <= next_shapeLamp;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode, scale and direction

  wire [3:0] lastMode = PULSE_VARIANT ? MODE_PULSE : MODE_VCO;
  wire [3:0] next_mode = (mode == MODE_NORMAL) ? MODE_SWEEP :
                         (mode == lastMode) ? MODE_NORMAL : {mode[2:0], 1'b0};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode <= MODE_NORMAL;
      logScale <= 1'b0;
      sweepDir <= DIR_UP;
      shownDir <= DIR_UP;
      showDir <= 1'b0;
      queryPrompt <= 1'b0;
      dutySetting <= DUTY_HALF;
    end else begin
      if (editIdle && modeKey) mode <= next_mode;
      if (doScale) logScale <= !logScale;
      if (doDirShow) shownDir <= sweepDir;
      else if (keyState == KEY_DIR && stepUp) shownDir <= shownDir + 2'h1;
      if (keyState == KEY_DIR && executeKey) sweepDir <= shownDir;
      showDir <= (keyState == KEY_DIR);
      queryPrompt <= armed && blinkPhase;
      dutySetting <= (mode == MODE_PULSE) ? pulseWidthSetting : DUTY_HALF;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sweep sequencer; position 0 is start, sweepPosMax is stop

  sweep_state_type sweepState;
  wire sweeping = (mode == MODE_SWEEP);
  wire [10:0] sweepPosMax = logScale ? LIN_MAX : stopLin;
  wire runTrig = !triggerMode || trigger;
  wire startsLow = (sweepDir == DIR_UP) || (sweepDir == DIR_UPDN);
  wire twoLeg = (sweepDir == DIR_UPDN) || (sweepDir == DIR_DNUP);
  wire [10:0] homePos = startsLow ? 11'h000 : sweepPosMax;
  wire [10:0] farPos = startsLow ? sweepPosMax : 11'h000;
  wire atFar = (sweepPos == farPos);
  wire atHome = (sweepPos == homePos);
  wire [10:0] towardFar = startsLow ? sweepPos + 11'h001 : sweepPos - 11'h001;
  wire [10:0] towardHome = startsLow ? sweepPos - 11'h001 : sweepPos + 11'h001;
  // Linear interpolation over the stop span; log shaping is left to the synthesis core
  wire [45:0] span = {11'h000, stopLog - startFreq} * {35'h0, sweepPos};
  wire [34:0] sweepFreq = startFreq + 35'(span / {35'h0, sweepPosMax});

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sweepState <= SW_IDLE;
      sweepPos <= 11'h000;
      outFreq <= FREQ_MIN;
    end else begin
      if (!sweeping) begin
        sweepState <= SW_IDLE;
        sweepPos <= 11'h000;
      end else begin
        unique case (sweepState)
          SW_IDLE: begin
            if (runTrig) begin
              sweepPos <= homePos;
              sweepState <= SW_FWD;
            end
          end
          SW_FWD: begin
            if (sweepTick) begin
              if (!atFar) sweepPos <= towardFar;
              else if (twoLeg) sweepState <= SW_BACK;
              else sweepState <= SW_IDLE;
            end
          end
          SW_BACK: begin
            if (sweepTick) begin
              if (!atHome) sweepPos <= towardHome;
              else sweepState <= SW_IDLE;
            end
          end
        endcase
      end
      if (mode == MODE_VCO) outFreq <= (vcoLevel < FREQ_MIN) ? FREQ_MIN :
                                       (vcoLevel > FREQ_MAX) ? FREQ_MAX : vcoLevel;
      else if (sweeping) outFreq <= sweepFreq;
      else outFreq <= startFreq;
    end
  end

endmodule

// ---- sweep_tick_src.sv ----
// Stand-in for the synthesis core: it paces the sweep with one-cycle ticks.
// Assumes the same clock and reset as the control block.
module sweep_tick_src (
  input wire logic clk,
  input wire logic rst_b,
  output logic tick
);
  // A tick every other cycle keeps the long log legs short in simulation
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick <= 1'b0;
    end else begin
      tick <= !tick;
    end
  end
endmodule

// ---- panel_ctrl_props.sv ----
// Checker on the front-panel control ports, bound into panel_ctrl.
// Assumes one clock, a sync active-low reset and the base shape set.
module panel_ctrl_checker
  import panel_ctrl_pkg::*;
(
  input wire logic clk, rst_b, shiftKey, outputDisconnectKey, outUpKey, outDownKey,
  input wire logic scaleKey, executeKey, outputConnected, logScale, showDir,
  input wire logic [34:0] vcoLevel, outFreq, startFreq,
  input wire logic [10:0] stopLin, markLin,
  input wire logic [4:0] cellIndex,
  input wire logic [3:0] shape, mode,
  input wire logic [13:0] shapeLamp,
  input wire logic [1:0] shownDir, sweepDir,
  input wire logic [7:0] dutySetting
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  freq_span_a: assert property (startFreq >= FREQ_MIN && startFreq <= FREQ_MAX)
    else $error("Start frequency out of span");
  lin_span_a: assert property (stopLin inside {[LIN_MIN:LIN_MAX]} && markLin >= LIN_MIN)
    else $error("Linear count out of span");
  cell_span_a: assert property (cellIndex <= CELL_MAX)
    else $error("Cell index out of span");
  shape_step_a: assert property (outputConnected && outUpKey |=>
    shape == (($past(shape) == SHAPE_LAST_BASE) ? 4'h0 : $past(shape) + 4'h1)) else $error("Bad step");
  standby_off_a: assert property (shiftKey ##[1:3] outputDisconnectKey |=>
    !outputConnected ##1 shapeLamp == 14'h0000) else $error("Stand-by not taken");
  standby_on_a: assert property (!outputConnected && (outUpKey || outDownKey) |=>
    outputConnected ##1 shapeLamp == 14'h0001 << shape) else $error("Reconnect failed");
  mode_onehot_a: assert property ($onehot0(mode))
    else $error("Mode not one-hot");
  scale_toggle_a: assert property (shiftKey ##[1:3] scaleKey |=> logScale != $past(logScale))
    else $error("Scale did not toggle");
  dir_apply_a: assert property (showDir && executeKey |=> sweepDir == $past(shownDir))
    else $error("Direction not applied");
  vco_follow_a: assert property (mode == MODE_VCO && $past(mode) == MODE_VCO &&
    $stable(vcoLevel) |=> outFreq == $past(vcoLevel)) else $error("Frequency ignores control");
  duty_half_a: assert property (mode != MODE_PULSE && $past(mode) != MODE_PULSE |->
    dutySetting == DUTY_HALF) else $error("Duty not half");
endmodule

bind panel_ctrl panel_ctrl_checker checker_i (.*);

// ---- testbench.sv ----
// Self-checking bench for the front-panel control block, base variant.
// Assumes keys are one-cycle pulses and a tick source paces sweeps.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [12:0] k = 13'h0000;
  wire shiftKey, outputDisconnectKey, outUpKey, outDownKey, modeKey, scaleKey, sweepTick;
  wire sweepDirectionKey, executeKey, stepUp, stepDown, rangeUp, rangeDown, trigger;
  logic [1:0] stepDigit = 2'h0;
  logic [2:0] paramSel = 3'h0;
  logic triggerMode = 1'b1;
  logic widthError = 1'b0;
  logic [7:0] pulseWidthSetting = 8'h40;
  logic [34:0] vcoLevel = 35'h0000_4E20;
  logic [34:0] outFreq, startFreq, stopLog, f;
  logic [10:0] stopLin, markLin, sweepPos, p;
  logic [4:0] cellIndex, busAddress;
  logic [3:0] shape, mode;
  logic [13:0] shapeLamp;
  logic [2:0] rangeIndex;
  logic [1:0] sweepDir, shownDir;
  logic [7:0] dutySetting;
  logic outputConnected, logScale, showDir, queryPrompt;
  int n_fail = 0;
  int comparisons = 0;
  int i, n;
  localparam int SH = 0, DIS = 1, OUP = 2, ODN = 3, MD = 4, SC = 5, SD = 6;
  localparam int EX = 7, SU = 8, SDN = 9, RU = 10, TR = 12;
  assign {trigger, rangeDown, rangeUp, stepDown, stepUp, executeKey, sweepDirectionKey} = k[12:6];
  assign {scaleKey, modeKey, outDownKey, outUpKey, outputDisconnectKey, shiftKey} = k[5:0];
  always #12.5 clk = ~clk;
  panel_ctrl #(.PULSE_VARIANT(1'b0), .BLINK_COUNT(4)) uut (.*);
  sweep_tick_src ticker (.clk(clk), .rst_b(rst_b), .tick(sweepTick));
  ////////////////////////////////////////
  task cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Gap after each key so one bit is never set and cleared in one step
  task press(input int j);
    @(posedge clk) k[j] <= 1'b1;
    @(posedge clk) k[j] <= 1'b0;
    cyc(2);
  endtask
  task sel(input logic [2:0] ps, input logic [1:0] sd);
    @(posedge clk);
    paramSel <= ps;
    stepDigit <= sd;
  endtask
  task chk(input logic [34:0] got, input logic [34:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  task set_dir(input logic [1:0] d);
    press(SH);
    press(SD);
    chk(35'(showDir), 35'h0000_0001);
    n = 0;
    while (shownDir !== d && n < 4) begin
      press(SU);
      n++;
    end
    chk(35'(shownDir), 35'(d));
    press(EX);
    chk(35'(sweepDir), 35'(d));
  endtask
  task summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    chk(35'(shapeLamp), 35'h0000_0001);
    press(SDN);
    chk(startFreq, 35'h0000_0002);
    press(SU);
    press(RU);
    chk(35'(rangeIndex), 35'h0000_0001);
    press(SU);
    chk(startFreq, 35'h0000_000B);
    sel(3'h2, 2'h2);
    press(SU);
    chk(35'(stopLin), 35'h0000_07D0);
    for (i = 0; i < 19; i++) press(SDN);
    chk(35'(stopLin), 35'h0000_0064);
    sel(3'h3, 2'h0);
    press(SDN);
    chk(35'(markLin), 35'h0000_0002);
    sel(3'h4, 2'h1);
    for (i = 0; i < 32; i++) press(SU);
    chk(35'(cellIndex), 35'h0000_001E);
    sel(3'h5, 2'h1);
    for (i = 0; i < 33; i++) press(SU);
    chk(35'(busAddress), 35'h0000_001F);
    sel(3'h0, 2'h0);
    for (i = 1; i <= 6; i++) begin
      press(OUP);
      cyc(1);
      chk(35'(shapeLamp), 35'(14'h0001 << (i % 6)));
    end
    press(ODN);
    press(SH);
    press(DIS);
    chk(35'({outputConnected, shapeLamp, shape}), 35'h0000_0005);
    press(ODN);
    cyc(1);
    chk(35'({outputConnected, shapeLamp, shape}), 35'h0004_0205);
    press(SH);
    press(SC);
    chk(35'(logScale), 35'h0000_0001);
    press(SH);
    n = 0;
    repeat (8) begin
      cyc(1);
      n = n | int'(queryPrompt);
    end
    chk(35'(n), 35'h0000_0001);
    press(SH);
    cyc(3);
    chk(35'(queryPrompt), 35'h0000_0000);
    press(SC);
    chk(35'(logScale), 35'h0000_0001);
    press(MD);
    chk(35'(mode), 35'h0000_0001);
    // Log first, then linear: log legs run the full count and take longest
    for (i = 0; i < 8; i++) begin
      if (i == 4) begin
        press(SH);
        press(SC);
      end
      set_dir(i[1:0]);
      press(TR);
      n = 0;
      do begin
        p = sweepPos;
        cyc(8);
        n++;
      end while (sweepPos !== p && n < 1200);
      f = outFreq;
      cyc(60);
      chk(outFreq, f);
      chk(35'(outFreq === startFreq), 35'(i % 4 == 1 || i % 4 == 2));
    end
    @(posedge clk) triggerMode <= 1'b0;
    cyc(40);
    p = sweepPos;
    cyc(20);
    chk(35'(sweepPos !== p), 35'h0000_0001);
    press(MD);
    cyc(2);
    chk(outFreq, 35'h0000_4E20);
    chk(35'({mode, dutySetting}), 35'h0000_0280);
    press(MD);
    chk(35'(mode), 35'h0000_0000);
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule
